// ===== fdc_curve.sv
// temperature to duty curve: floor below start, sloped rise above
`timescale 1ns/1ps
`include "fdc_map.svh"
module fdc_curve (
  input  wire logic [7:0] temp,
  input  wire logic [7:0] curve,
  input  wire logic [7:0] floor_duty,
  output logic      [7:0] target
);
  logic [7:0]  start_temp;
  logic [2:0]  slope;
  logic [7:0]  excess;
  logic [15:0] rise;
  logic [15:0] sum;

  // start temperature counts in steps of 4 degrees
  assign start_temp = {1'b0,
    curve[`FDC_CURVE_TEMP_HI:`FDC_CURVE_TEMP_LO], 2'b00};
  assign slope  = curve[`FDC_CURVE_SLP_HI:`FDC_CURVE_SLP_LO];
  assign excess = (temp > start_temp) ? 8'(temp - start_temp) : 8'h00;
  assign rise   = 16'({8'h00, excess} << slope);
  assign sum    = rise + {8'h00, floor_duty};
  // floor at or below start, saturate at full scale
  assign target = (sum > 16'h00ff) ? 8'hff : sum[7:0];
endmodule

// ===== fdc_duty_regs.sv
// fan duty control registers with pwm output, axi4-lite slave
`timescale 1ns/1ps
`include "fdc_map.svh"
// Contract
// - auto mode at or below start temperature drives floor duty; floor resets 0x55.
// - manual mode duty write takes effect on the output at once.
// - duty register is 8 bits, about 0.39% per code, resets 0x55.
// - reading the duty register returns the duty now driving the pin.
// - manual mode written duty value drives the fan output.
// - other modes keep written duty in a holding register, output unaffected.
// - switching to manual mode drives output from the holding register at once.
// - ramp register 0x52: enable, step, rate, threshold used in auto mode.
// - local curve 0x41: start temperature bits 7:3, slope bits 2:0.
// - remote curve 0x61: start temperature bits 7:3, slope bits 2:0.
module fdc_duty_regs
  import fdc_pkg::*;
#(
  parameter int unsigned ADDR_W      = 8,
  parameter int unsigned TICK_CYCLES =
    `FDC_TICK_US * 1000 / `FDC_CLK_NS
) (
  input  wire logic              clk_sys,
  input  wire logic              reset,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [7:0]        local_temp,
  input  wire logic [7:0]        remote_temp,
  output logic                   pwm_out
);
  // byte address of each register is four times its index
  localparam logic [7:0] A_FLOOR  = {`FDC_IDX_FLOOR, 2'b00};
  localparam logic [7:0] A_DUTY   = {`FDC_IDX_DUTY, 2'b00};
  localparam logic [7:0] A_RAMP   = {`FDC_IDX_RAMP, 2'b00};
  localparam logic [7:0] A_LCURVE = {`FDC_IDX_LCURVE, 2'b00};
  localparam logic [7:0] A_RCURVE = {`FDC_IDX_RCURVE, 2'b00};
  localparam logic [7:0] A_MODE   = {`FDC_IDX_MODE, 2'b00};
  localparam logic [7:0] A_STATUS = {`FDC_IDX_STATUS, 2'b00};
  localparam int unsigned TW      = $clog2(TICK_CYCLES + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

  // ---- write channel capture
  logic              aw_full_q;
  logic              w_full_q;
  logic [7:0]        aw_addr_q;
  logic [7:0]        w_data_q;
  logic              w_lane0_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              wr_fire;
  logic              wr_hit;
  logic              wr_floor;
  logic              wr_duty;
  logic              wr_ramp;
  logic              wr_lcurve;
  logic              wr_rcurve;
  logic              wr_mode;

  assign s_axi_awready = !aw_full_q && !bvalid_q;
  assign s_axi_wready  = !w_full_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign wr_fire   = aw_full_q && w_full_q && !bvalid_q;
  assign wr_floor  = wr_fire && w_lane0_q && (aw_addr_q == A_FLOOR);
  assign wr_duty   = wr_fire && w_lane0_q && (aw_addr_q == A_DUTY);
  assign wr_ramp   = wr_fire && w_lane0_q && (aw_addr_q == A_RAMP);
  assign wr_lcurve = wr_fire && w_lane0_q && (aw_addr_q == A_LCURVE);
  assign wr_rcurve = wr_fire && w_lane0_q && (aw_addr_q == A_RCURVE);
  assign wr_mode   = wr_fire && w_lane0_q && (aw_addr_q == A_MODE);
  assign wr_hit = (aw_addr_q == A_FLOOR) || (aw_addr_q == A_DUTY) ||
                  (aw_addr_q == A_RAMP) || (aw_addr_q == A_LCURVE) ||
                  (aw_addr_q == A_RCURVE) || (aw_addr_q == A_MODE) ||
                  (aw_addr_q == A_STATUS);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full_q <= 1'b1;
      aw_addr_q <= 8'({s_axi_awaddr[ADDR_W-1:2], 2'b00});
    end else if (wr_fire) begin
      aw_full_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      w_full_q  <= 1'b0;
      w_data_q  <= 8'h00;
      w_lane0_q <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full_q  <= 1'b1;
      w_data_q  <= s_axi_wdata[7:0];
      w_lane0_q <= s_axi_wstrb[0];
    end else if (wr_fire) begin
      w_full_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `FDC_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? `FDC_RESP_OKAY : `FDC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // ---- register file
  logic [7:0]   floor_q;
  logic [7:0]   hold_q;
  logic [7:0]   hold_d;
  logic [7:0]   ramp_q;
  logic [7:0]   lcurve_q;
  logic [7:0]   rcurve_q;
  logic [1:0]   mode_sel_q;
  fdc_mode_type mode;
  logic         mode_manual;

  assign mode = (mode_sel_q == 2'h0) ? FDC_MODE_MANUAL :
                (mode_sel_q == 2'h1) ? FDC_MODE_LOCAL  :
                (mode_sel_q == 2'h2) ? FDC_MODE_REMOTE : FDC_MODE_MAX;
  assign mode_manual = (mode == FDC_MODE_MANUAL);
  // writes in any mode land in the holding register
  assign hold_d = wr_duty ? w_data_q : hold_q;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      floor_q    <= `FDC_RST_FLOOR;
      hold_q     <= `FDC_RST_DUTY;
      ramp_q     <= `FDC_RST_RAMP;
      lcurve_q   <= `FDC_RST_LCURVE;
      rcurve_q   <= `FDC_RST_RCURVE;
      mode_sel_q <= `FDC_RST_MODE;
    end else begin
      hold_q <= hold_d;
      if (wr_floor)  floor_q    <= w_data_q;
      if (wr_ramp)   ramp_q     <= w_data_q;
      if (wr_lcurve) lcurve_q   <= w_data_q;
      if (wr_rcurve) rcurve_q   <= w_data_q;
      if (wr_mode)   mode_sel_q <= w_data_q[1:0];
    end
  end

  // ---- automatic curve targets
  logic [7:0] local_target;
  logic [7:0] remote_target;
  logic [7:0] auto_target;

  fdc_curve u_local_curve (
    .temp       (local_temp),
    .curve      (lcurve_q),
    .floor_duty (floor_q),
    .target     (local_target)
  );

  fdc_curve u_remote_curve (
    .temp       (remote_temp),
    .curve      (rcurve_q),
    .floor_duty (floor_q),
    .target     (remote_target)
  );

  assign auto_target =
    (mode == FDC_MODE_LOCAL)  ? local_target  :
    (mode == FDC_MODE_REMOTE) ? remote_target :
    (local_target > remote_target) ? local_target : remote_target;

  // ---- ramp timing
  logic          ramp_en;
  logic [7:0]    ramp_step;
  logic [2:0]    ramp_rate;
  logic [7:0]    ramp_thr;
  logic [TW-1:0] tick_cnt_q;
  logic [2:0]    rate_cnt_q;
  logic          tick;
  logic          ramp_tick;

  assign ramp_en   = ramp_q[`FDC_RAMP_EN_BIT];
  assign ramp_step = 8'h01 << ramp_q[`FDC_RAMP_STEP_HI:`FDC_RAMP_STEP_LO];
  assign ramp_rate = ramp_q[`FDC_RAMP_RATE_HI:`FDC_RAMP_RATE_LO];
  assign ramp_thr  = 8'h01 << ramp_q[`FDC_RAMP_THR_HI:`FDC_RAMP_THR_LO];
  assign tick      = (tick_cnt_q == TICK_LAST);
  // update period is (rate + 1) base ticks
  assign ramp_tick = tick && (rate_cnt_q >= ramp_rate);

  always_ff @(posedge clk_sys) begin
    if (reset || tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + TW'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset || ramp_tick) begin
      rate_cnt_q <= 3'h0;
    end else if (tick) begin
      rate_cnt_q <= rate_cnt_q + 3'h1;
    end
  end

  // ---- live duty selection
  logic [7:0] duty_q;
  logic [7:0] duty_d;
  logic [7:0] ramp_next;
  logic [7:0] gap;
  logic [8:0] up_sum;

  assign gap = (auto_target > duty_q) ? 8'(auto_target - duty_q) :
                                        8'(duty_q - auto_target);
  assign up_sum = {1'b0, duty_q} + {1'b0, ramp_step};
  assign ramp_next =
    (gap < ramp_thr)          ? duty_q :
    (gap <= ramp_step)        ? auto_target :
    (auto_target > duty_q)    ? up_sum[7:0] : 8'(duty_q - ramp_step);
  // manual mode drives straight from the written value
  assign duty_d = mode_manual ? hold_d :
                  !ramp_en    ? auto_target :
                  ramp_tick   ? ramp_next : duty_q;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      duty_q <= `FDC_RST_DUTY;
    end else begin
      duty_q <= duty_d;
    end
  end

  // ---- pwm: period of 255 clocks, code 255 is full on
  logic [7:0] pwm_cnt_q;
  logic       pwm_q;

  always_ff @(posedge clk_sys) begin
    if (reset || pwm_cnt_q == `FDC_PWM_TOP) begin
      pwm_cnt_q <= 8'h00;
    end else begin
      pwm_cnt_q <= pwm_cnt_q + 8'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pwm_q <= 1'b0;
    end else begin
      pwm_q <= (pwm_cnt_q < duty_d);
    end
  end
  assign pwm_out = pwm_q;

  // ---- read channel
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic [7:0]  rd_addr;
  logic        rd_fire;
  logic [31:0] rd_word;
  logic        rd_hit;

  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign rd_fire = s_axi_arvalid && !rvalid_q;
  assign rd_addr = 8'({s_axi_araddr[ADDR_W-1:2], 2'b00});
  assign rd_hit  = (rd_addr == A_FLOOR) || (rd_addr == A_DUTY) ||
                   (rd_addr == A_RAMP) || (rd_addr == A_LCURVE) ||
                   (rd_addr == A_RCURVE) || (rd_addr == A_MODE) ||
                   (rd_addr == A_STATUS);
  // duty register reads back the live duty
  assign rd_word =
    (rd_addr == A_FLOOR)  ? {24'h0, floor_q}  :
    (rd_addr == A_DUTY)   ? {24'h0, duty_q}   :
    (rd_addr == A_RAMP)   ? {24'h0, ramp_q}   :
    (rd_addr == A_LCURVE) ? {24'h0, lcurve_q} :
    (rd_addr == A_RCURVE) ? {24'h0, rcurve_q} :
    (rd_addr == A_MODE)   ? {30'h0, mode_sel_q} :
    (rd_addr == A_STATUS) ? {8'h0, auto_target, hold_q, duty_q} : 32'h0;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0;
      rresp_q  <= `FDC_RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_word;
      rresp_q  <= rd_hit ? `FDC_RESP_OKAY : `FDC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ---- assertions
  property p_floor;
    @(posedge clk_sys) disable iff (reset)
    (mode == FDC_MODE_LOCAL) && !ramp_en &&
    (local_temp <= {1'b0, lcurve_q[7:3], 2'b00}) |=> duty_q == $past(floor_q);
  endproperty
  a_floor: assert property (p_floor)
    else $error("auto duty not at floor");

  property p_manual_write;
    @(posedge clk_sys) disable iff (reset)
    wr_duty && mode_manual |=> duty_q == $past(w_data_q) ##1
      (!mode_manual || wr_duty || duty_q == $past(duty_q));
  endproperty
  a_manual_write: assert property (p_manual_write)
    else $error("manual duty write not applied");

  property p_reset_vals;
    @(posedge clk_sys)
    reset |=> duty_q == 8'h55 && floor_q == 8'h55 && ramp_q == 8'h52 &&
      lcurve_q == 8'h41 && rcurve_q == 8'h61;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("register reset value wrong");

  property p_read_duty;
    @(posedge clk_sys) disable iff (reset)
    rd_fire && rd_addr == A_DUTY |=> s_axi_rdata == {24'h0, $past(duty_q)};
  endproperty
  a_read_duty: assert property (p_read_duty)
    else $error("duty read not live value");

  property p_hold;
    @(posedge clk_sys) disable iff (reset)
    wr_duty && !mode_manual && !ramp_en |=> hold_q == $past(w_data_q) &&
      duty_q == $past(auto_target);
  endproperty
  a_hold: assert property (p_hold)
    else $error("holding register not loaded");

  property p_switch;
    @(posedge clk_sys) disable iff (reset)
    $rose(mode_manual) |-> ##1 duty_q == $past(hold_d);
  endproperty
  a_switch: assert property (p_switch)
    else $error("switch to manual not applied");

  property p_ramp_hold;
    @(posedge clk_sys) disable iff (reset)
    !mode_manual && ramp_en && !ramp_tick && !$past(mode_manual)
      |=> duty_q == $past(duty_q);
  endproperty
  a_ramp_hold: assert property (p_ramp_hold)
    else $error("ramped duty moved off tick");

  property p_curve;
    @(posedge clk_sys) disable iff (reset)
    (mode == FDC_MODE_REMOTE) && !ramp_en |=> duty_q == $past(remote_target);
  endproperty
  a_curve: assert property (p_curve)
    else $error("auto duty not following curve");

  property p_pwm_ends;
    @(posedge clk_sys) disable iff (reset)
    duty_q == 8'h00 && $past(duty_q) == 8'h00 ##1 duty_q == 8'h00
      |-> !pwm_out;
  endproperty
  a_pwm_ends: assert property (p_pwm_ends)
    else $error("pwm high at zero duty");
endmodule

// ===== fdc_fan_meter.sv
// fan side model: counts pwm high cycles over the last pwm period
`timescale 1ns/1ps
module fdc_fan_meter (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       pwm_out,
  output logic      [7:0] high_count
);
  logic [254:0] hist_q;
  // one full period of 255 clocks gives the duty code directly
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      hist_q <= '0;
    end else begin
      hist_q <= {hist_q[253:0], pwm_out};
    end
  end
  assign high_count = 8'($countones(hist_q));
endmodule

// ===== fdc_map.svh
// register offsets, field positions, reset values and timing for fan duty
`ifndef FDC_MAP_SVH
`define FDC_MAP_SVH
`define FDC_IDX_FLOOR      6'h21
`define FDC_IDX_DUTY       6'h22
`define FDC_IDX_RAMP       6'h23
`define FDC_IDX_LCURVE     6'h24
`define FDC_IDX_RCURVE     6'h25
`define FDC_IDX_MODE       6'h30
`define FDC_IDX_STATUS     6'h31
`define FDC_RST_FLOOR      8'h55
`define FDC_RST_DUTY       8'h55
`define FDC_RST_RAMP       8'h52
`define FDC_RST_LCURVE     8'h41
`define FDC_RST_RCURVE     8'h61
`define FDC_RST_MODE       2'h0
`define FDC_RAMP_EN_BIT    7
`define FDC_RAMP_STEP_HI   6
`define FDC_RAMP_STEP_LO   5
`define FDC_RAMP_RATE_HI   4
`define FDC_RAMP_RATE_LO   2
`define FDC_RAMP_THR_HI    1
`define FDC_RAMP_THR_LO    0
`define FDC_CURVE_TEMP_HI  7
`define FDC_CURVE_TEMP_LO  3
`define FDC_CURVE_SLP_HI   2
`define FDC_CURVE_SLP_LO   0
`define FDC_PWM_TOP        8'hfe
`define FDC_CLK_NS         10
`define FDC_TICK_US        1000
`define FDC_RESP_OKAY      2'b00
`define FDC_RESP_SLVERR    2'b10
`endif

// ===== fdc_pkg.sv
// types shared by the fan duty control block
package fdc_pkg;
  typedef enum logic [3:0] {
    FDC_MODE_MANUAL = 4'b0001,
    FDC_MODE_LOCAL  = 4'b0010,
    FDC_MODE_REMOTE = 4'b0100,
    FDC_MODE_MAX    = 4'b1000
  } fdc_mode_type;
endpackage

// ===== tb_top.sv
// self-checking bench for the fan duty control registers
`timescale 1ns/1ps
`include "fdc_map.svh"
module tb_top;
  logic        clk_sys;
  logic        reset;
  logic [7:0]  awaddr, araddr, local_temp, remote_temp, fan_duty;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, pwm_out;
  logic [31:0] dv;
  int          n_errors = 0;
  int          checked = 0;
  logic [5:0]  ridx [5] = '{`FDC_IDX_FLOOR, `FDC_IDX_DUTY, `FDC_IDX_RAMP,
                            `FDC_IDX_LCURVE, `FDC_IDX_RCURVE};
  logic [7:0]  rrst [5] = '{`FDC_RST_FLOOR, `FDC_RST_DUTY, `FDC_RST_RAMP,
                            `FDC_RST_LCURVE, `FDC_RST_RCURVE};
  logic [7:0]  mdv [3] = '{8'h00, 8'h80, 8'hff};

  fdc_duty_regs #(.TICK_CYCLES(4)) u_fdc_duty_regs (
    .clk_sys(clk_sys), .reset(reset),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .local_temp(local_temp),
    .remote_temp(remote_temp), .pwm_out(pwm_out));

  fdc_fan_meter u_fdc_fan_meter (.clk_sys(clk_sys), .reset(reset),
    .pwm_out(pwm_out), .high_count(fan_duty));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  function automatic logic [7:0] ba(input logic [5:0] idx);
    return {idx, 2'b00};
  endfunction

  task automatic close_out();
    if (n_errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int  n;
    bit  aw_done, w_done;
    n = 0; aw_done = 0; w_done = 0;
    awaddr <= a; wdata <= {24'h0, d};
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (!aw_done && awready === 1'b1) begin
        aw_done = 1; awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1) begin
        w_done = 1; wvalid <= 1'b0;
      end
      if (bvalid === 1'b1) begin
        resp = bresp; bready <= 1'b0;
        break;
      end
      if (++n > 100) begin
        n_errors++; bready <= 1'b0;
        break;
      end
    end
    // idle edge keeps back-to-back strobes apart
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    bit ar_done;
    n = 0; ar_done = 0;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (!ar_done && arready === 1'b1) begin
        ar_done = 1; arvalid <= 1'b0;
      end
      if (rvalid === 1'b1) begin
        resp = rresp; dv = rdata; rready <= 1'b0;
        break;
      end
      if (++n > 100) begin
        n_errors++; rready <= 1'b0;
        break;
      end
    end
    @(posedge clk_sys);
  endtask

  task automatic duty_is(input logic [7:0] exp);
    repeat (5) @(posedge clk_sys);
    rd(ba(`FDC_IDX_DUTY));
    chk("duty", dv, {24'h0, exp});
  endtask

  initial begin
    reset = 1'b1; awaddr = '0; araddr = '0; wdata = '0; wstrb = 4'hf;
    awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
    local_temp = 8'h14; remote_temp = 8'h32;
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    for (int i = 0; i < 5; i++) begin
      rd(ba(ridx[i]));
      chk("reset value", dv, {24'h0, rrst[i]});
      wr(ba(ridx[i]), ~rrst[i]);
      rd(ba(ridx[i]));
      chk("readback", dv, {24'h0, ~rrst[i]});
    end
    rd(8'h00);
    chk("unmapped read", {dv[29:0], resp}, 32'h2);
    wr(8'h00, 8'h12);
    chk("unmapped write", resp, 2'b10);
    wstrb <= 4'h0;
    wr(ba(`FDC_IDX_DUTY), 8'h11);
    wstrb <= 4'hf;
    duty_is(~`FDC_RST_DUTY);
    for (int i = 0; i < 3; i++) begin
      wr(ba(`FDC_IDX_DUTY), mdv[i]);
      rd(ba(`FDC_IDX_DUTY));
      chk("manual duty", dv, {24'h0, mdv[i]});
      repeat (260) @(posedge clk_sys);
      chk("fan duty", fan_duty, mdv[i]);
    end
    wr(ba(`FDC_IDX_FLOOR), 8'h30);
    wr(ba(`FDC_IDX_RAMP), `FDC_RST_RAMP);
    wr(ba(`FDC_IDX_LCURVE), `FDC_RST_LCURVE);
    wr(ba(`FDC_IDX_RCURVE), `FDC_RST_RCURVE);
    wr(ba(`FDC_IDX_MODE), 8'h01);
    duty_is(8'h30);
    wr(ba(`FDC_IDX_DUTY), 8'h77);
    duty_is(8'h30);
    rd(ba(`FDC_IDX_STATUS));
    chk("holding", dv[15:8], 8'h77);
    local_temp <= 8'h28;
    duty_is(8'h40);
    local_temp <= 8'hc8;
    duty_is(8'hff);
    wr(ba(`FDC_IDX_MODE), 8'h02);
    duty_is(8'h34);
    wr(ba(`FDC_IDX_MODE), 8'h03);
    duty_is(8'hff);
    rd(ba(`FDC_IDX_STATUS));
    chk("auto target", dv[23:16], 8'hff);
    local_temp <= 8'h28;
    wr(ba(`FDC_IDX_LCURVE), 8'h42);
    wr(ba(`FDC_IDX_MODE), 8'h01);
    duty_is(8'h50);
    // ramp on before the drop, so duty walks down instead of jumping
    wr(ba(`FDC_IDX_RAMP), 8'h80);
    local_temp <= 8'h14;
    rd(ba(`FDC_IDX_DUTY));
    chk("ramp moving", dv[7:0] > 8'h30, 1'b1);
    repeat (200) @(posedge clk_sys);
    duty_is(8'h30);
    wr(ba(`FDC_IDX_MODE), 8'h00);
    rd(ba(`FDC_IDX_DUTY));
    chk("switch to manual", dv, 32'h77);
    repeat (260) @(posedge clk_sys);
    chk("fan duty", fan_duty, 8'h77);
    close_out();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    close_out();
  end
endmodule
